/* dcpll_pkg.sv */
`default_nettype none
package dcpll_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  typedef logic [ADDR_W-1:0] dcpll_addr_t;

  localparam dcpll_addr_t ADDR_CHIP_IRQ_ENABLE       = 12'h01f;
  localparam dcpll_addr_t ADDR_CHIP_IRQ_STATUS_CLEAR = 12'h023;
  localparam dcpll_addr_t ADDR_PLL_CONTROL           = 12'h083;
  localparam dcpll_addr_t ADDR_PLL_STATUS            = 12'h084;
  localparam dcpll_addr_t ADDR_FEEDBACK_DIVIDE_COUNT = 12'h085;
  localparam dcpll_addr_t ADDR_LOOP_FILTER_CONFIG_A  = 12'h087;
  localparam dcpll_addr_t ADDR_LOOP_FILTER_CONFIG_B  = 12'h088;
  localparam dcpll_addr_t ADDR_LOOP_FILTER_CONFIG_C  = 12'h089;
  localparam dcpll_addr_t ADDR_CHARGE_PUMP_CURRENT   = 12'h08a;
  localparam dcpll_addr_t ADDR_VCO_OUTPUT_DIVIDER    = 12'h08b;
  localparam dcpll_addr_t ADDR_REFERENCE_DIVIDER     = 12'h08c;
  localparam dcpll_addr_t ADDR_VCO_TRACKING_A        = 12'h1b4;
  localparam dcpll_addr_t ADDR_VCO_TRACKING_B        = 12'h1b6;
  localparam dcpll_addr_t ADDR_VCO_TRACKING_C        = 12'h1bb;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_IRQ_LOCK    = 5;
  localparam int BIT_IRQ_LOST    = 4;
  localparam int BIT_CTRL_EN     = 4;
  localparam int BIT_CTRL_RECAL  = 7;
  localparam int BIT_ST_LOCK     = 1;
  localparam int BIT_ST_CAL_DONE = 5;
  localparam int BIT_ST_EDGE_LO  = 6;
  localparam int BIT_ST_EDGE_HI  = 7;
  localparam int CP_CUR_MSB      = 5;
  localparam int REF_CODE_MSB    = 2;
  localparam int VCO_CODE_MSB    = 1;
  localparam int EVT_LOCK        = 1;
  localparam int EVT_LOST        = 0;

  // ----------------------------------------------------------------
  // Reset values and decode constants
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [7:0] RST_FB_COUNT = 8'h06;
  localparam logic [2:0] REF_CODE_MAX = 3'h5;
  localparam logic [1:0] VCO_CODE_8   = 2'h2;
  localparam logic [1:0] VCO_CODE_16  = 2'h3;
  localparam logic [4:0] VCO_RATIO_4  = 5'h04;
  localparam logic [4:0] VCO_RATIO_8  = 5'h08;
  localparam logic [4:0] VCO_RATIO_16 = 5'h10;
  localparam logic [8:0] RATIO_ONE    = 9'h001;

  // ----------------------------------------------------------------
  // Loop behaviour
  // ----------------------------------------------------------------
  localparam logic [8:0] BAND_MID      = 9'h100;
  localparam logic [8:0] BAND_MAX      = 9'h1ff;
  localparam logic [8:0] BAND_MIN      = 9'h000;
  localparam logic [8:0] BAND_STEP     = 9'h001;
  localparam logic [7:0] ERR_LOCK_MAX  = 8'h02;
  localparam logic [7:0] ERR_STEER_MIN = 8'h08;
  localparam logic [7:0] ERR_SAT       = 8'hff;
  localparam logic [7:0] GOOD_LOCK     = 8'h10;
  localparam logic [7:0] CNT_STEP      = 8'h01;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int CAL_TIME_NS   = 50000;
  localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [11:0] CAL_LAST = 12'(CAL_CYCLES - 1);

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF    = 4'b0001,
    ST_CAL    = 4'b0010,
    ST_SEARCH = 4'b0100,
    ST_TRACK  = 4'b1000
  } dcpll_state_t;

  typedef struct packed {
    logic [3:0] c1;
    logic [3:0] c2;
    logic [3:0] c3;
    logic [3:0] r1;
    logic [3:0] r3;
  } dcpll_lf_t;

  typedef struct packed {
    logic       pll_enable;
    logic       sample_clock_from_pll;
    logic [5:0] cp_current;
    dcpll_lf_t  loop_filter;
    logic [8:0] vco_band;
    logic [4:0] vco_output_division_ratio;
    logic [7:0] vco_tracking_a;
    logic [7:0] vco_tracking_b;
    logic [7:0] vco_tracking_c;
  } dcpll_ana_t;

  typedef struct packed {
    logic [8:0] cnt;
    logic       tick;
  } dcpll_div_st_t;

  typedef struct packed {
    logic [1:0]   ref_sync;
    logic         ref_d;
    logic [1:0]   fb_sync;
    logic         fb_d;
    logic [1:0]   irq_en;
    logic [1:0]   irq_src;
    logic [1:0]   evt_d;
    logic [7:0]   ctrl;
    logic [7:0]   fb_count;
    logic [7:0]   lf_a;
    logic [7:0]   lf_b;
    logic [7:0]   lf_c;
    logic [7:0]   cp;
    logic [7:0]   vco_div;
    logic [7:0]   ref_div;
    logic [7:0]   trk_a;
    logic [7:0]   trk_b;
    logic [7:0]   trk_c;
    dcpll_state_t state;
    logic [11:0]  cal_cnt;
    logic         cal_done;
    logic [8:0]   band;
    logic         edge_hi;
    logic         edge_lo;
    logic         pfd_up;
    logic         pfd_dn;
    logic [7:0]   err_cnt;
    logic [7:0]   good_cnt;
    logic         locked;
    logic [7:0]   rdata;
    logic         rvalid;
  } dcpll_st_t;

endpackage
`default_nettype wire

/* dcpll_div.sv */
`default_nettype none
module dcpll_div (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       tick_in,
  input  wire logic [8:0] ratio,
  output logic            tick_out
);

  dcpll_pkg::dcpll_div_st_t s_r;
  dcpll_pkg::dcpll_div_st_t s_nxt;

  // ----------------------------------------------------------------
  // Edge counter; a ratio of zero behaves as one
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (clear) begin
      s_nxt.cnt = '0;
    end else if (tick_in) begin
      if (9'(s_r.cnt + dcpll_pkg::RATIO_ONE) >= ratio) begin
        s_nxt.cnt  = '0;
        s_nxt.tick = 1'b1;
      end else begin
        s_nxt.cnt = 9'(s_r.cnt + dcpll_pkg::RATIO_ONE);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick_out = s_r.tick;

endmodule
`default_nettype wire

/* dcpll_top.sv */
// What this block does
// - Sample clock comes from the reference input directly or from the on-chip PLL.
// - Five loop filter parts, 4-bit code each, from three filter registers.
// - Charge pump current is a 6-bit code in the low six register bits.
// - First enable calibrates the VCO, then status bit 5 rises.
// - Reference divider code selects ratio 1, 2, 4, 8, 16 (and 32).
// - Feedback count 6-127 is eight bits; the loop divides by twice it.
// - Detector compares divided reference with divided feedback, pulses pump up/down.
// - VCO divider code 1, 2, 3 selects 4, 8, 16; host keeps VCO in range.
// - Device picks one of 512 VCO bands and keeps lock over temperature.
// - Lock shows in status bit 1, readable by the host.
// - Status bits 7 and 6 flag upper and lower band edge reached.
// - Writing control bit 7 from 0 to 1 makes the device recalibrate.
// - Lock and lost are interrupt events, enable bits 5/4, status bits 5/4.
// - Disabled event holds latch at 0; enabled rising edge latches; latch pulls line low.
// - Status read gives latch when enabled, live event level when not.
`default_nettype none
module dcpll_top (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic                        reference_clock_in,
  input  wire logic                        converter_sample_clock,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  input  wire logic [dcpll_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  output logic      [7:0]                  reg_rdata,
  output logic                             reg_rvalid,
  output logic                             cp_up,
  output logic                             cp_down,
  output dcpll_pkg::dcpll_ana_t            ana,
  output logic                             irq_n_o,
  output logic                             irq_n_oe
);

  dcpll_pkg::dcpll_st_t s_r;
  dcpll_pkg::dcpll_st_t s_nxt;

  logic       ref_edge;
  logic       fb_edge;
  logic       ref_tick;
  logic       fb_tick;
  logic       pll_en;
  logic [8:0] ref_ratio;
  logic [8:0] fb_ratio;
  logic [1:0] evt_live;

  // ----------------------------------------------------------------
  // Decoders
  // ----------------------------------------------------------------
  function automatic logic [8:0] ref_ratio_of(input logic [2:0] code);
    logic [2:0] c;
    c = (code > dcpll_pkg::REF_CODE_MAX) ? dcpll_pkg::REF_CODE_MAX : code;
    return 9'(dcpll_pkg::RATIO_ONE << c);
  endfunction

  function automatic logic [4:0] vco_ratio_of(input logic [1:0] code);
    logic [4:0] r;
    r = dcpll_pkg::VCO_RATIO_4;
    if (code == dcpll_pkg::VCO_CODE_8) begin
      r = dcpll_pkg::VCO_RATIO_8;
    end else if (code == dcpll_pkg::VCO_CODE_16) begin
      r = dcpll_pkg::VCO_RATIO_16;
    end
    return r;
  endfunction

  function automatic logic irq_view(input logic en, input logic src, input logic live);
    return en ? src : live;
  endfunction

  // ----------------------------------------------------------------
  // Input edges and dividers
  // ----------------------------------------------------------------
  assign pll_en    = s_r.ctrl[dcpll_pkg::BIT_CTRL_EN];
  assign ref_edge  = s_r.ref_sync[1] & ~s_r.ref_d;
  assign fb_edge   = s_r.fb_sync[1] & ~s_r.fb_d;
  assign ref_ratio = ref_ratio_of(s_r.ref_div[dcpll_pkg::REF_CODE_MSB:0]);
  assign fb_ratio  = {s_r.fb_count, 1'b0};

  dcpll_div u_ref_div (
    .clk      (clk),
    .rst      (rst),
    .clear    (~pll_en),
    .tick_in  (ref_edge),
    .ratio    (ref_ratio),
    .tick_out (ref_tick)
  );

  dcpll_div u_fb_div (
    .clk      (clk),
    .rst      (rst),
    .clear    (~pll_en),
    .tick_in  (fb_edge),
    .ratio    (fb_ratio),
    .tick_out (fb_tick)
  );

  // Lost is only meaningful once the loop is running after calibration
  assign evt_live[dcpll_pkg::EVT_LOCK] = s_r.locked;
  assign evt_live[dcpll_pkg::EVT_LOST] = ~s_r.locked & pll_en & s_r.cal_done;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic       up_n;
    logic       dn_n;
    logic       cmp_done;
    logic       recal;
    logic [1:0] clr;
    s_nxt          = s_r;
    up_n           = 1'b0;
    dn_n           = 1'b0;
    cmp_done       = 1'b0;
    recal          = 1'b0;
    clr            = 2'b00;
    s_nxt.rvalid   = 1'b0;
    s_nxt.ref_sync = {s_r.ref_sync[0], reference_clock_in};
    s_nxt.ref_d    = s_r.ref_sync[1];
    s_nxt.fb_sync  = {s_r.fb_sync[0], converter_sample_clock};
    s_nxt.fb_d     = s_r.fb_sync[1];

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        dcpll_pkg::ADDR_CHIP_IRQ_ENABLE: begin
          s_nxt.irq_en = {reg_wdata[dcpll_pkg::BIT_IRQ_LOCK], reg_wdata[dcpll_pkg::BIT_IRQ_LOST]};
        end
        dcpll_pkg::ADDR_CHIP_IRQ_STATUS_CLEAR: begin
          clr = {reg_wdata[dcpll_pkg::BIT_IRQ_LOCK], reg_wdata[dcpll_pkg::BIT_IRQ_LOST]};
        end
        dcpll_pkg::ADDR_PLL_CONTROL: begin
          recal      = reg_wdata[dcpll_pkg::BIT_CTRL_RECAL] &
                       ~s_r.ctrl[dcpll_pkg::BIT_CTRL_RECAL];
          s_nxt.ctrl = reg_wdata;
        end
        dcpll_pkg::ADDR_FEEDBACK_DIVIDE_COUNT: s_nxt.fb_count = reg_wdata;
        dcpll_pkg::ADDR_LOOP_FILTER_CONFIG_A:  s_nxt.lf_a     = reg_wdata;
        dcpll_pkg::ADDR_LOOP_FILTER_CONFIG_B:  s_nxt.lf_b     = reg_wdata;
        dcpll_pkg::ADDR_LOOP_FILTER_CONFIG_C:  s_nxt.lf_c     = reg_wdata;
        dcpll_pkg::ADDR_CHARGE_PUMP_CURRENT:   s_nxt.cp       = reg_wdata;
        dcpll_pkg::ADDR_VCO_OUTPUT_DIVIDER:    s_nxt.vco_div  = reg_wdata;
        dcpll_pkg::ADDR_REFERENCE_DIVIDER:     s_nxt.ref_div  = reg_wdata;
        dcpll_pkg::ADDR_VCO_TRACKING_A:        s_nxt.trk_a    = reg_wdata;
        dcpll_pkg::ADDR_VCO_TRACKING_B:        s_nxt.trk_b    = reg_wdata;
        dcpll_pkg::ADDR_VCO_TRACKING_C:        s_nxt.trk_c    = reg_wdata;
        default: begin
        end
      endcase
    end

    // Phase frequency detector: both flags set means reset together
    up_n = s_r.pfd_up | ref_tick;
    dn_n = s_r.pfd_dn | fb_tick;
    if (up_n & dn_n) begin
      cmp_done = 1'b1;
      up_n     = 1'b0;
      dn_n     = 1'b0;
    end
    s_nxt.pfd_up = up_n;
    s_nxt.pfd_dn = dn_n;
    if ((s_r.pfd_up | s_r.pfd_dn) && (s_r.err_cnt != dcpll_pkg::ERR_SAT)) begin
      s_nxt.err_cnt = 8'(s_r.err_cnt + dcpll_pkg::CNT_STEP);
    end

    // Loop sequencer
    unique case (s_r.state)
      dcpll_pkg::ST_OFF: begin
        if (pll_en) begin
          s_nxt.state = s_r.cal_done ? dcpll_pkg::ST_SEARCH : dcpll_pkg::ST_CAL;
          s_nxt.cal_cnt = '0;
        end
      end
      dcpll_pkg::ST_CAL: begin
        if (s_r.cal_cnt == dcpll_pkg::CAL_LAST) begin
          s_nxt.cal_done = 1'b1;
          s_nxt.state    = dcpll_pkg::ST_SEARCH;
        end else begin
          s_nxt.cal_cnt = 12'(s_r.cal_cnt + 12'h001);
        end
      end
      dcpll_pkg::ST_SEARCH, dcpll_pkg::ST_TRACK: begin
        if (cmp_done) begin
          s_nxt.err_cnt = '0;
          if (s_r.err_cnt <= dcpll_pkg::ERR_LOCK_MAX) begin
            if (s_r.good_cnt != dcpll_pkg::GOOD_LOCK) begin
              s_nxt.good_cnt = 8'(s_r.good_cnt + dcpll_pkg::CNT_STEP);
            end
          end else begin
            s_nxt.good_cnt = '0;
          end
          // Band steering runs in both states so drift over temperature is followed
          if (s_r.err_cnt >= dcpll_pkg::ERR_STEER_MIN) begin
            if (s_r.pfd_up) begin
              if (s_r.band == dcpll_pkg::BAND_MAX) begin
                s_nxt.edge_hi = 1'b1;
              end else begin
                s_nxt.band = 9'(s_r.band + dcpll_pkg::BAND_STEP);
              end
            end else begin
              if (s_r.band == dcpll_pkg::BAND_MIN) begin
                s_nxt.edge_lo = 1'b1;
              end else begin
                s_nxt.band = 9'(s_r.band - dcpll_pkg::BAND_STEP);
              end
            end
          end
        end
        if (s_nxt.good_cnt == dcpll_pkg::GOOD_LOCK) begin
          s_nxt.state = dcpll_pkg::ST_TRACK;
        end
      end
    endcase

    // Recalibration restarts from the middle band
    if (recal) begin
      s_nxt.state    = dcpll_pkg::ST_CAL;
      s_nxt.cal_cnt  = '0;
      s_nxt.cal_done = 1'b0;
      s_nxt.band     = dcpll_pkg::BAND_MID;
      s_nxt.edge_hi  = 1'b0;
      s_nxt.edge_lo  = 1'b0;
      s_nxt.good_cnt = '0;
    end

    // Disable wins over everything, but calibration stays valid
    if (!s_nxt.ctrl[dcpll_pkg::BIT_CTRL_EN]) begin
      s_nxt.state    = dcpll_pkg::ST_OFF;
      s_nxt.good_cnt = '0;
      s_nxt.err_cnt  = '0;
      s_nxt.pfd_up   = 1'b0;
      s_nxt.pfd_dn   = 1'b0;
    end
    s_nxt.locked = (s_nxt.state == dcpll_pkg::ST_TRACK) && s_nxt.cal_done &&
                   (s_nxt.good_cnt == dcpll_pkg::GOOD_LOCK);

    // Interrupt latches: a new edge beats a clear in the same cycle
    s_nxt.evt_d = evt_live;
    for (int i = 0; i < 2; i++) begin
      s_nxt.irq_src[i] = s_nxt.irq_en[i] &
                         ((s_r.irq_src[i] & ~clr[i]) |
                          (evt_live[i] & ~s_r.evt_d[i]));
    end

    // Register reads, answered one cycle later
    if (reg_rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = dcpll_pkg::RST_BYTE;
      unique case (reg_addr)
        dcpll_pkg::ADDR_CHIP_IRQ_ENABLE: begin
          s_nxt.rdata[dcpll_pkg::BIT_IRQ_LOCK] = s_r.irq_en[dcpll_pkg::EVT_LOCK];
          s_nxt.rdata[dcpll_pkg::BIT_IRQ_LOST] = s_r.irq_en[dcpll_pkg::EVT_LOST];
        end
        dcpll_pkg::ADDR_CHIP_IRQ_STATUS_CLEAR: begin
          s_nxt.rdata[dcpll_pkg::BIT_IRQ_LOCK] = irq_view(s_r.irq_en[dcpll_pkg::EVT_LOCK],
            s_r.irq_src[dcpll_pkg::EVT_LOCK], evt_live[dcpll_pkg::EVT_LOCK]);
          s_nxt.rdata[dcpll_pkg::BIT_IRQ_LOST] = irq_view(s_r.irq_en[dcpll_pkg::EVT_LOST],
            s_r.irq_src[dcpll_pkg::EVT_LOST], evt_live[dcpll_pkg::EVT_LOST]);
        end
        dcpll_pkg::ADDR_PLL_CONTROL: s_nxt.rdata = s_r.ctrl;
        dcpll_pkg::ADDR_PLL_STATUS: begin
          s_nxt.rdata[dcpll_pkg::BIT_ST_LOCK]     = s_r.locked;
          s_nxt.rdata[dcpll_pkg::BIT_ST_CAL_DONE] = s_r.cal_done;
          s_nxt.rdata[dcpll_pkg::BIT_ST_EDGE_LO]  = s_r.edge_lo;
          s_nxt.rdata[dcpll_pkg::BIT_ST_EDGE_HI]  = s_r.edge_hi;
        end
        dcpll_pkg::ADDR_FEEDBACK_DIVIDE_COUNT: s_nxt.rdata = s_r.fb_count;
        dcpll_pkg::ADDR_LOOP_FILTER_CONFIG_A:  s_nxt.rdata = s_r.lf_a;
        dcpll_pkg::ADDR_LOOP_FILTER_CONFIG_B:  s_nxt.rdata = s_r.lf_b;
        dcpll_pkg::ADDR_LOOP_FILTER_CONFIG_C:  s_nxt.rdata = s_r.lf_c;
        dcpll_pkg::ADDR_CHARGE_PUMP_CURRENT:   s_nxt.rdata = s_r.cp;
        dcpll_pkg::ADDR_VCO_OUTPUT_DIVIDER:    s_nxt.rdata = s_r.vco_div;
        dcpll_pkg::ADDR_REFERENCE_DIVIDER:     s_nxt.rdata = s_r.ref_div;
        dcpll_pkg::ADDR_VCO_TRACKING_A:        s_nxt.rdata = s_r.trk_a;
        dcpll_pkg::ADDR_VCO_TRACKING_B:        s_nxt.rdata = s_r.trk_b;
        dcpll_pkg::ADDR_VCO_TRACKING_C:        s_nxt.rdata = s_r.trk_c;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r          <= '0;
      s_r.state    <= dcpll_pkg::ST_OFF;
      s_r.fb_count <= dcpll_pkg::RST_FB_COUNT;
      s_r.band     <= dcpll_pkg::BAND_MID;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata  = s_r.rdata;
  assign reg_rvalid = s_r.rvalid;
  assign cp_up      = s_r.pfd_up;
  assign cp_down    = s_r.pfd_dn;

  assign ana.pll_enable                = pll_en;
  assign ana.sample_clock_from_pll     = pll_en;
  assign ana.cp_current                = s_r.cp[dcpll_pkg::CP_CUR_MSB:0];
  assign ana.loop_filter.c1            = s_r.lf_a[3:0];
  assign ana.loop_filter.c2            = s_r.lf_a[7:4];
  assign ana.loop_filter.c3            = s_r.lf_b[3:0];
  assign ana.loop_filter.r1            = s_r.lf_b[7:4];
  assign ana.loop_filter.r3            = s_r.lf_c[3:0];
  assign ana.vco_band                  = s_r.band;
  assign ana.vco_output_division_ratio =
    vco_ratio_of(s_r.vco_div[dcpll_pkg::VCO_CODE_MSB:0]);
  assign ana.vco_tracking_a            = s_r.trk_a;
  assign ana.vco_tracking_b            = s_r.trk_b;
  assign ana.vco_tracking_c            = s_r.trk_c;

  // Open-drain request: only ever pulls low, shared line needs a pull-up
  assign irq_n_o  = 1'b0;
  assign irq_n_oe = |s_r.irq_src;

endmodule
`default_nettype wire

/* dcpll_top_unused_never.sv */
`default_nettype none
`default_nettype wire

/* dcpll_top_assertions.sv */
`default_nettype none
module dcpll_top_assertions (
  input wire logic                         clk,
  input wire logic                         rst,
  input wire logic                         reg_wr,
  input wire logic                         reg_rd,
  input wire logic [dcpll_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [7:0]                   reg_wdata,
  input wire logic                         reg_rvalid,
  input wire logic                         cp_up,
  input wire logic                         cp_down,
  input wire dcpll_pkg::dcpll_ana_t        ana,
  input wire logic                         irq_n_o,
  input wire logic                         irq_n_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  chk_rvalid_cause: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without request");
  chk_enable_write: assert property (reg_wr && reg_addr == 12'h083 |=>
    ana.pll_enable == $past(reg_wdata[4]) && ana.sample_clock_from_pll == ana.pll_enable)
    else $error("enable does not follow control write");
  chk_pump_write: assert property (reg_wr && reg_addr == 12'h08a |=>
    ana.cp_current == $past(reg_wdata[5:0])) else $error("pump current wrong");
  chk_filter_write: assert property (reg_wr && reg_addr == 12'h087 |=>
    {ana.loop_filter.c2, ana.loop_filter.c1} == $past(reg_wdata))
    else $error("filter code wrong");
  chk_vco_ratio: assert property (reg_wr && reg_addr == 12'h08b &&
    reg_wdata[1:0] == 2'h3 |=> ana.vco_output_division_ratio == 5'h10)
    else $error("vco ratio not 16");
  chk_pump_quiet: assert property (!ana.pll_enable ##1 !ana.pll_enable |->
    !cp_up && !cp_down) else $error("pump active while disabled");
  chk_pump_single: assert property (!(cp_up && cp_down))
    else $error("pump up and down together");
  chk_irq_low_only: assert property (irq_n_o == 1'b0)
    else $error("request line driven high");
  // Dropping both enables must release the shared request line at once
  chk_irq_disable: assert property (reg_wr && reg_addr == 12'h01f &&
    reg_wdata[5:4] == 2'h0 |=> !irq_n_oe) else $error("request held while disabled");
endmodule
bind dcpll_top dcpll_top_assertions dcpll_top_assertions_inst (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .cp_up(cp_up), .cp_down(cp_down),
  .ana(ana), .irq_n_o(irq_n_o), .irq_n_oe(irq_n_oe));
`default_nettype wire

/* dcpll_clk_src.sv */
`default_nettype none
module dcpll_clk_src #(
  parameter int HALF_NS = 50
) (
  input  wire logic run,
  output logic      reference_clock_in,
  output logic      converter_sample_clock
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------
  // Reference source and ideal locked VCO
  // ----------------------------------------
  initial reference_clock_in = 1'b0;
  always begin
    #(HALF_NS);
    reference_clock_in = run ? ~reference_clock_in : 1'b0;
  end
  // Feedback edges land with the reference, so the detector sees no phase error
  assign converter_sample_clock = reference_clock_in;
endmodule
`default_nettype wire

/* dcpll_top_test.sv */
`default_nettype none
module dcpll_top_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, run, refc, smpc, reg_wr, reg_rd, rvalid, up, dn, irq_o, irq_oe;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, rdata;
  dcpll_pkg::dcpll_ana_t ana;
  int num_errors = 0;
  int tests_run = 0;
  logic [8:0] vco_exp [4] = '{9'h004, 9'h004, 9'h008, 9'h010};
  // ----------------------------------------
  // Harness and access tasks
  // ----------------------------------------
  dcpll_clk_src dcpll_clk_src_inst (.run(run), .reference_clock_in(refc),
    .converter_sample_clock(smpc));
  dcpll_top dcpll_top_inst (.clk(clk), .rst(rst), .reference_clock_in(refc),
    .converter_sample_clock(smpc), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_rvalid(rvalid), .cp_up(up),
    .cp_down(dn), .ana(ana), .irq_n_o(irq_o), .irq_n_oe(irq_oe));
  always #12.5 clk = ~clk;
  task automatic check(input string name, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    d = rvalid ? rdata : 8'hxx;
  endtask
  task automatic rdchk(input string name, input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(name, {1'b0, exp}, {1'b0, d});
  endtask
  task automatic poll(input int b, input string name);
    logic [7:0] d;
    int n;
    n = 0;
    d = 8'h00;
    while (d[b] !== 1'b1 && n < 200) begin
      repeat (20) @(negedge clk);
      rd(12'h084, d);
      n++;
    end
    check(name, 9'h001, {8'h00, d[b]});
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #400us;
    num_errors++;
    final_report();
  end
  initial begin
    {clk, rst, run, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b010, 2'b00, 12'h000, 8'h00};
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rdchk("feedback reset", 12'h085, 8'h06);
    check("band mid", 9'h100, ana.vco_band);
    rdchk("control reset", 12'h083, 8'h00);
    rdchk("unmapped", 12'h086, 8'h00);
    wr(12'h084, 8'hff);
    rdchk("status read only", 12'h084, 8'h00);
    for (int c = 0; c < 5; c++) begin
      wr(12'h08c, 8'(c));
      rdchk("ref code", 12'h08c, 8'(c));
      wr(12'h08b, 8'(c % 4));
      check("vco ratio", vco_exp[c % 4], 9'(ana.vco_output_division_ratio));
    end
    $display("test registers done");
    wr(12'h087, 8'h62);
    wr(12'h088, 8'hc9);
    wr(12'h089, 8'h0e);
    wr(12'h08a, 8'h12);
    check("filter c2 c1", 9'h062, {1'b0, ana.loop_filter.c2, ana.loop_filter.c1});
    check("filter r1 c3", 9'h0c9, {1'b0, ana.loop_filter.r1, ana.loop_filter.c3});
    check("filter r3", 9'h00e, 9'(ana.loop_filter.r3));
    check("pump current", 9'h012, 9'(ana.cp_current));
    wr(12'h08b, 8'h02);
    wr(12'h085, 8'h08);
    wr(12'h08c, 8'h04);
    wr(12'h1b4, 8'h60);
    wr(12'h1b6, 8'h49);
    wr(12'h1bb, 8'h13);
    check("tracking a", 9'h060, 9'(ana.vco_tracking_a));
    check("tracking b", 9'h049, 9'(ana.vco_tracking_b));
    check("tracking c", 9'h013, 9'(ana.vco_tracking_c));
    wr(12'h01f, 8'h30);
    run = 1'b1;
    wr(12'h083, 8'h10);
    rdchk("status early", 12'h084, 8'h00);
    poll(5, "cal done");
    poll(1, "lock");
    $display("test lock done");
    check("irq line", 9'h001, 9'(irq_oe));
    rdchk("irq latched", 12'h023, 8'h30);
    wr(12'h023, 8'h30);
    rdchk("irq cleared", 12'h023, 8'h00);
    check("irq released", 9'h000, 9'(irq_oe));
    wr(12'h01f, 8'h00);
    rdchk("irq live", 12'h023, 8'h20);
    wr(12'h083, 8'h00);
    rdchk("lock off", 12'h084, 8'h20);
    wr(12'h083, 8'h10);
    wr(12'h083, 8'h90);
    rdchk("recal", 12'h084, 8'h00);
    $display("test events done");
    // Feedback ratio 14 against 16: feedback ticks first, so the pump steers down
    wr(12'h083, 8'h00);
    wr(12'h085, 8'h07);
    wr(12'h083, 8'h10);
    for (int n = 0; n < 200 && dn !== 1'b1; n++) @(negedge clk);
    check("pump down", 9'h001, 9'(dn));
    check("pump not up", 9'h000, 9'(up));
    // Feedback ratio 18 against 16: reference ticks first, so the pump steers up
    wr(12'h083, 8'h00);
    wr(12'h085, 8'h09);
    wr(12'h083, 8'h10);
    for (int n = 0; n < 200 && up !== 1'b1; n++) @(negedge clk);
    check("pump up", 9'h001, 9'(up));
    check("pump not down", 9'h000, 9'(dn));
    $display("test pump done");
    final_report();
  end
endmodule
`default_nettype wire
